// >>> shared/sipo_latch_pkg.sv
package sipo_latch_pkg;

   // Register width and stage positions
   localparam int WIDTH = 8;
   localparam int LAST_STAGE = 7;
   localparam int STAGE_SIX = 6;

   // Values after reset
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] STORE_RESET = 8'h00;

   // Two-entry buffer depth
   localparam int BUF_DEPTH = 2;

   // Edge events seen on the pin clocks, sampled in the same cycle
   typedef struct packed {
      logic shift_rise;
      logic store_rise;
   } edge_type;

   // Word handed from the shift side to the storage side
   typedef struct packed {
      logic [7:0] data;
   } word_type;

endpackage

// >>> verilog/two_entry_buffer.sv
`timescale 1ns/1ns
// Two-entry FIFO with valid and ready on both sides
module two_entry_buffer #(
   parameter int DW = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [DW-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [DW-1:0] out_data_o
);
   logic [DW-1:0] mem_reg [DEPTH];
   logic [$clog2(DEPTH)-1:0] wr_ptr_reg;
   logic [$clog2(DEPTH)-1:0] rd_ptr_reg;
   logic [$clog2(DEPTH):0] count_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   // Honest full and empty straight from the count
   assign in_ready_o = (count_reg != DEPTH[$clog2(DEPTH):0]);
   assign out_valid_o = (count_reg != '0);
   assign out_data_o = mem_reg[rd_ptr_reg];

   // Pointers wrap at depth, which is a power of two here
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
      end
   end

   // Storage has no reset; only written entries are read
   always_ff @(posedge mclk_i) begin
      if (push) mem_reg[wr_ptr_reg] <= in_data_i;
   end
endmodule // two_entry_buffer

// >>> verilog/serial_in_parallel_out_latch.sv
`timescale 1ns/1ns
// Contract
// - 8-bit shift register feeding 8-bit storage
// - Separate shift and storage clocks
// - Low master clear zeroes shift stages
// - Shift clock rise advances, serial in enters
// - Storage clock rise copies stages to outputs
// - Tied clocks: storage lags by one pulse
// - Parallel outputs driven when enable low, else off
// - Output enable never touches register contents
// - During clear serial out low, storage kept
// - Storage edge during clear loads zeros
// - Stage 0 takes input, others shift
// - Storage-only edge leaves serial out alone
// - Coincident edges transfer pre-shift contents
// - Last stage drives serial out
module serial_in_parallel_out_latch #(
   parameter int WIDTH = sipo_latch_pkg::WIDTH
) (
   // System clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Pins from the host, asynchronous to mclk_i
   input wire logic serial_in_i,
   input wire logic shift_clock_i,
   input wire logic storage_clock_i,
   input wire logic master_clear_n_i,
   input wire logic output_enable_n_i,
   // Pins to the host
   output logic serial_out_o,
   output logic [WIDTH-1:0] parallel_outputs_o,
   output logic [WIDTH-1:0] parallel_outputs_oe_o
);
   // Two-flop synchronisers for every pin input
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic shift_clk_d_reg;
   logic store_clk_d_reg;
   logic [WIDTH-1:0] shift_reg;
   logic [WIDTH-1:0] shift_next;
   logic [WIDTH-1:0] store_reg;
   logic serial_out_reg;
   logic [WIDTH-1:0] oe_reg;
   sipo_latch_pkg::edge_type edges;
   sipo_latch_pkg::word_type word_in;
   sipo_latch_pkg::word_type word_out;
   logic buf_out_valid;
   logic [WIDTH-1:0] buf_out_data;

   // Clear and enable bits reset to their idle high level, so that
   // the parallel outputs are not driven and no clear is seen before the sync fills
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_reg <= 5'h18;
         sync2_reg <= 5'h18;
      end else begin
         sync1_reg <= {output_enable_n_i, master_clear_n_i, storage_clock_i,
                       shift_clock_i, serial_in_i};
         sync2_reg <= sync1_reg;
      end
   end

   // Named views of the synchronised pins
   wire din_s = sync2_reg[0];
   wire shclk_s = sync2_reg[1];
   wire stclk_s = sync2_reg[2];
   wire clear_n_s = sync2_reg[3];
   wire oe_n_s = sync2_reg[4];

   // Rising-edge detection on the sampled pin clocks
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_clk_d_reg <= 1'b0;
         store_clk_d_reg <= 1'b0;
      end else begin
         shift_clk_d_reg <= shclk_s;
         store_clk_d_reg <= stclk_s;
      end
   end
   assign edges.shift_rise = shclk_s && !shift_clk_d_reg;
   assign edges.store_rise = stclk_s && !store_clk_d_reg;

   // Next shift contents: stage 0 takes input, rest move up
   assign shift_next = {shift_reg[WIDTH-2:0], din_s};

   // Shift register; clear holds it at zero while low. Clear is
   // sampled, so it acts a few mclk cycles after the pin falls.
   // A storage edge alone never moves the stages; the buffer never
   // fills because its drain side is always ready.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_reg <= sipo_latch_pkg::SHIFT_RESET;
      end else if (!clear_n_s) begin
         shift_reg <= sipo_latch_pkg::SHIFT_RESET;
      end else if (edges.shift_rise) begin
         shift_reg <= shift_next;
      end
   end

   // Word snapshot goes into the buffer; taking shift_reg before the
   // update gives pre-shift contents on coincident edges
   assign word_in.data = clear_n_s ? shift_reg : sipo_latch_pkg::SHIFT_RESET;

   two_entry_buffer #(
      .DW(WIDTH),
      .DEPTH(sipo_latch_pkg::BUF_DEPTH)
   ) u_buf (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(edges.store_rise),
      .in_ready_o(),
      .in_data_i(word_in.data),
      .out_valid_o(buf_out_valid),
      .out_ready_i(1'b1),
      .out_data_o(buf_out_data)
   );
   assign word_out.data = buf_out_data;

   // Storage register: changes only on a buffered transfer, never on
   // clear or output enable activity
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         store_reg <= sipo_latch_pkg::STORE_RESET;
      end else if (buf_out_valid) begin
         store_reg <= word_out.data;
      end
   end

   // Serial out: last stage, forced low during clear
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_out_reg <= 1'b0;
      end else begin
         serial_out_reg <= clear_n_s ? shift_reg[sipo_latch_pkg::LAST_STAGE] : 1'b0;
      end
   end

   // Output enables; only the drivers change, registers do not
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oe_reg <= '0;
      end else begin
         oe_reg <= {WIDTH{!oe_n_s}};
      end
   end

   assign serial_out_o = serial_out_reg;
   assign parallel_outputs_o = store_reg;
   assign parallel_outputs_oe_o = oe_reg;
endmodule // serial_in_parallel_out_latch

// >>> verif/sipo_latch_sva.sv
`timescale 1ns/1ns
module sipo_latch_sva #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Pins from the host
   input wire logic shift_clock_i,
   input wire logic storage_clock_i,
   input wire logic master_clear_n_i,
   input wire logic output_enable_n_i,
   // Pins to the host
   input wire logic serial_out_o,
   input wire logic [WIDTH-1:0] parallel_outputs_o,
   input wire logic [WIDTH-1:0] parallel_outputs_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // Clear held low on both sides of a storage edge, long enough to pass the sync
   sequence clr_store_seq;
      (!master_clear_n_i)[*4] ##1 ($rose(storage_clock_i) && !master_clear_n_i)
         ##1 (!master_clear_n_i)[*4];
   endsequence

   // Relations at the pins, windows sized for the two-flop sync latency
   chk_reset_quiet: assert property ($rose(rst_n_i) |-> parallel_outputs_o == '0 && !serial_out_o)
      else $error("outputs not zero after reset");
   chk_oe_off: assert property (output_enable_n_i[*5] |-> parallel_outputs_oe_o == '0)
      else $error("outputs driven while disabled");
   chk_oe_on: assert property ((!output_enable_n_i)[*5] |-> parallel_outputs_oe_o == '1)
      else $error("outputs not driven while enabled");
   chk_oe_uniform: assert property (parallel_outputs_oe_o == '0 || parallel_outputs_oe_o == '1)
      else $error("output enables disagree");
   chk_clear_serial: assert property ((!master_clear_n_i)[*5] |-> !serial_out_o)
      else $error("serial out high during clear");
   chk_store_hold: assert property ($stable(storage_clock_i)[*8] |-> $stable(parallel_outputs_o))
      else $error("parallel outputs moved without storage edge");
   chk_serial_hold: assert property (($stable(shift_clock_i) && master_clear_n_i)[*8]
      |-> $stable(serial_out_o)) else $error("serial out moved without shift edge");
   chk_clear_load: assert property (clr_store_seq |-> ##[0:2] parallel_outputs_o == '0)
      else $error("storage edge in clear did not load zeros");
endmodule // sipo_latch_sva

bind serial_in_parallel_out_latch sipo_latch_sva #(.WIDTH(WIDTH)) chk_u (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .shift_clock_i(shift_clock_i), .storage_clock_i(storage_clock_i),
   .master_clear_n_i(master_clear_n_i), .output_enable_n_i(output_enable_n_i),
   .serial_out_o(serial_out_o), .parallel_outputs_o(parallel_outputs_o),
   .parallel_outputs_oe_o(parallel_outputs_oe_o));

// >>> verif/sipo_host_model.sv
`timescale 1ns/1ns
module sipo_host_model (
   // Clock
   input wire logic mclk_i,
   // Pins to the device
   output logic serial_in_o = 1'b0,
   output logic shift_clock_o = 1'b0,
   output logic storage_clock_o = 1'b0,
   output logic master_clear_n_o = 1'b1,
   output logic output_enable_n_o = 1'b1
);
   // One 400 ns link period; clocks stand low between frames
   task automatic pulse(input logic bit_v, input logic sh, input logic st);
      serial_in_o <= bit_v;
      repeat (4) @(posedge mclk_i);
      shift_clock_o <= sh;
      storage_clock_o <= st;
      repeat (4) @(posedge mclk_i);
      shift_clock_o <= 1'b0;
      storage_clock_o <= 1'b0;
      serial_in_o <= ~bit_v; // Hold over: data no longer valid
   endtask

   // Level pins, then time for the sync to settle
   task automatic set_lines(input logic clr_n, input logic oe_n);
      master_clear_n_o <= clr_n;
      output_enable_n_o <= oe_n;
      repeat (6) @(posedge mclk_i);
   endtask
endmodule // sipo_host_model

// >>> verif/tb_serial_in_parallel_out_latch.sv
`timescale 1ns/1ns
module tb_serial_in_parallel_out_latch;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sin, shc, stc, clr_n, oe_n, sout, b, sh, st;
   logic [7:0] par, par_oe;
   logic [7:0] shift_m = 8'h00;
   logic [7:0] store_m = 8'h00;
   int fails = 0;
   int cmp_count = 0;
   integer seed = 32'h2f38_139a;

   // 20 MHz system clock
   always #25 mclk_i = ~mclk_i;

   sipo_host_model host_u (.mclk_i(mclk_i), .serial_in_o(sin), .shift_clock_o(shc),
      .storage_clock_o(stc), .master_clear_n_o(clr_n), .output_enable_n_o(oe_n));
   serial_in_parallel_out_latch dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .serial_in_i(sin),
      .shift_clock_i(shc), .storage_clock_i(stc), .master_clear_n_i(clr_n),
      .output_enable_n_i(oe_n), .serial_out_o(sout), .parallel_outputs_o(par),
      .parallel_outputs_oe_o(par_oe));

   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // First three frames force store-only, shift-only, both; then random mixes
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      chk({7'h00, sout}, 8'h00);
      host_u.set_lines(1'b1, 1'b0);
      chk(par_oe, 8'hff);
      for (int i = 0; i < 40; i++) begin
         b = 1'($random(seed));
         {sh, st} = (i < 3) ? 2'(i + 1) : 2'($random(seed));
         host_u.pulse(b, sh, st);
         repeat (4) @(posedge mclk_i);
         if (st) store_m = shift_m;
         if (sh) shift_m = {shift_m[6:0], b};
         chk(par, store_m);
         chk({7'h00, sout}, {7'h00, shift_m[7]});
      end
      // Disabled outputs; a shift meanwhile must not disturb storage
      host_u.set_lines(1'b1, 1'b1);
      chk(par_oe, 8'h00);
      host_u.pulse(1'b1, 1'b1, 1'b0);
      shift_m = {shift_m[6:0], 1'b1};
      host_u.set_lines(1'b1, 1'b0);
      chk(par, store_m);
      chk({7'h00, sout}, {7'h00, shift_m[7]});
      // Clear keeps storage until a storage edge loads zeros
      host_u.set_lines(1'b0, 1'b0);
      shift_m = 8'h00;
      chk({7'h00, sout}, 8'h00);
      chk(par, store_m);
      host_u.pulse(1'b1, 1'b0, 1'b1);
      repeat (4) @(posedge mclk_i);
      chk(par, 8'h00);
      close_out();
   end
endmodule // tb_serial_in_parallel_out_latch
